// [verilog/pa_mux_pkg.sv]
// Package: register map, field positions, reset values and modes
// for the port A pin-function block.
// Assumes a 32-bit APB register bus with word-aligned registers.
package pa_mux_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CPU_CTRL  = 8'h00;
  localparam logic [7:0] OFS_IF_CFG    = 8'h04;
  localparam logic [7:0] OFS_PA_CFG    = 8'h08;
  localparam logic [7:0] OFS_IRQ_TYPE  = 8'h0C;
  localparam logic [7:0] OFS_FIFO_POL  = 8'h10;
  localparam logic [7:0] OFS_WAKE_CTRL = 8'h14;
  localparam logic [7:0] OFS_PA_OE     = 8'h18;
  localparam logic [7:0] OFS_PA_OUT    = 8'h1C;
  localparam logic [7:0] OFS_PA_PINS   = 8'h20;
  localparam logic [7:0] OFS_SUSPEND   = 8'h24;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h2C;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CPU_TRI_BIT    = 1;  // Clock output tri-state
  localparam int CPU_SPD_LO     = 3;  // Clock speed field [4:3]
  localparam int PA_CFG_EXT_INTERRUPT_0_INPUT    = 0;  // Bit 0 is interrupt 0 input
  localparam int PA_CFG_EXT_INTERRUPT_1_INPUT    = 1;  // Bit 1 is interrupt 1 input
  localparam int IRQ_TYPE_IT0   = 0;  // Interrupt 0 trigger type
  localparam int IRQ_TYPE_IT1   = 2;  // Interrupt 1 trigger type
  localparam int FIFO_POL_OE    = 4;  // Output-enable polarity
  localparam int WAKE_EN_BIT    = 1;  // Second wake enable
  localparam int WAKE_POL_BIT   = 4;  // Second wake polarity
  localparam int WAKE_SEL_BIT   = 7;  // Bit 3 wake function select
  localparam int SUSP_REQ_BIT   = 0;  // Suspend request / state
  localparam int ST_EXT_INTERRUPT_0_INPUT        = 0;  // Status: interrupt 0
  localparam int ST_EXT_INTERRUPT_1_INPUT        = 1;  // Status: interrupt 1
  localparam int ST_WAKE        = 2;  // Status: wake-up
  localparam int ST_REFUSED     = 3;  // Status: suspend refused
  localparam int NUM_EVENTS     = 4;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CPU_CTRL  = 8'h00;
  localparam logic [1:0] RST_IF_CFG    = 2'h0;
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [3:0] RST_NIBBLE    = 4'h0;

  // ---------------------------------------------------------------
  // Modes
  // ---------------------------------------------------------------
  localparam logic [1:0] SPD_12 = 2'h0;
  localparam logic [1:0] SPD_24 = 2'h1;
  localparam logic [1:0] IF_PORT_A   = 2'h0;
  localparam logic [1:0] IF_PORT_B   = 2'h1;
  localparam logic [1:0] IF_MASTER   = 2'h2;
  localparam logic [1:0] IF_SLAVE    = 2'h3;

  typedef enum logic {PW_RUN, PW_SUSPENDED} power_e;

endpackage

// [verilog/irq_input_sense.sv]
// Active-low external interrupt input conditioner.
// Assumes the pin is already synchronous to the clock.
`timescale 1ns/10ps
module irq_input_sense
  import pa_mux_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Pin and mode
  input  wire logic pin_n,
  input  wire logic edge_mode,
  input  wire logic active,
  // Request to the status register
  output logic      request
);

  logic prev_q;
  logic prev_d;
  logic req_q;
  logic req_d;

  // Edge mode fires on a falling edge, level mode while low
  always_comb begin
    prev_d = pin_n;
    if (!active) begin
      req_d = 1'b0;
    end else if (edge_mode) begin
      req_d = prev_q & ~pin_n;
    end else begin
      req_d = ~pin_n;
    end
  end

  // Holds the previous pin level and the registered request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b1;
      req_q  <= 1'b0;
    end else begin
      prev_q <= prev_d;
      req_q  <= req_d;
    end
  end

  assign request = req_q;

endmodule

// [verilog/port_a_pin_function_select.sv]
// Port A bits 0..3 and clock output pin-function selection, with
// APB registers, sticky interrupt status and suspend/wake control.
// Assumes synchronous pins, a 20 MHz CLOCK and phase-locked 12, 24
// and 48 MHz clock sources supplied from outside.
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/10ps
module port_a_pin_function_select
  import pa_mux_pkg::*;
(
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Locked clock sources
  input  wire logic        CLK12_SRC,
  input  wire logic        CLK24_SRC,
  input  wire logic        CLK48_SRC,
  // Clock output pin
  output logic             CLOCK_OUTPUT_PIN_O,
  output logic             CLOCK_OUTPUT_PIN_OE_N,
  // Port A bits 0..3 pins
  input  wire logic [3:0]  PORT_A_IN,
  output logic [3:0]       PORT_A_OUT,
  output logic [3:0]       PORT_A_OE_N,
  // Slave FIFO data bus drive enable
  output logic             FIFO_DRIVE_EN,
  // Interface mode for the rest of the chip
  output logic [1:0]       INTERFACE_MODE,
  // Power control
  output logic             OSC_RUN,
  output logic             SUSPENDED,
  // Interrupt
  output logic             IRQ
);

  // -------------------------------------------------------------
  // Reset release
  // -------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // -------------------------------------------------------------
  // Register decode
  // -------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, OFS_CPU_CTRL)  | hit(a, OFS_IF_CFG)   |
             hit(a, OFS_PA_CFG)    | hit(a, OFS_IRQ_TYPE) |
             hit(a, OFS_FIFO_POL)  | hit(a, OFS_WAKE_CTRL) |
             hit(a, OFS_PA_OE)     | hit(a, OFS_PA_OUT)   |
             hit(a, OFS_PA_PINS)   | hit(a, OFS_SUSPEND)  |
             hit(a, OFS_IRQ_STAT)  | hit(a, OFS_IRQ_MASK);
  endfunction

  logic setup;
  logic wr;

  // Setup phase captures read data; write lands in access phase
  assign setup  = PSEL & ~PENABLE;
  assign wr     = PSEL & PENABLE & PWRITE;
  assign PREADY = PSEL & PENABLE;

  // -------------------------------------------------------------
  // Configuration registers
  // -------------------------------------------------------------
  logic [7:0] cpu_ctrl_q, cpu_ctrl_d;
  logic [1:0] if_cfg_q, if_cfg_d;
  logic [7:0] pa_cfg_q, pa_cfg_d;
  logic [7:0] irq_type_q, irq_type_d;
  logic [7:0] fifo_pol_q, fifo_pol_d;
  logic [7:0] wake_ctrl_q, wake_ctrl_d;
  logic [3:0] pa_oe_q, pa_oe_d;
  logic [3:0] pa_out_q, pa_out_d;
  logic [NUM_EVENTS-1:0] irq_mask_q, irq_mask_d;

  // Software writes to the configuration registers
  always_comb begin
    cpu_ctrl_d  = cpu_ctrl_q;
    if_cfg_d    = if_cfg_q;
    pa_cfg_d    = pa_cfg_q;
    irq_type_d  = irq_type_q;
    fifo_pol_d  = fifo_pol_q;
    wake_ctrl_d = wake_ctrl_q;
    pa_oe_d     = pa_oe_q;
    pa_out_d    = pa_out_q;
    irq_mask_d  = irq_mask_q;
    if (wr) begin
      if (hit(PADDR, OFS_CPU_CTRL))  cpu_ctrl_d  = PWDATA[7:0];
      if (hit(PADDR, OFS_IF_CFG))    if_cfg_d    = PWDATA[1:0];
      if (hit(PADDR, OFS_PA_CFG))    pa_cfg_d    = PWDATA[7:0];
      if (hit(PADDR, OFS_IRQ_TYPE))  irq_type_d  = PWDATA[7:0];
      if (hit(PADDR, OFS_FIFO_POL))  fifo_pol_d  = PWDATA[7:0];
      if (hit(PADDR, OFS_WAKE_CTRL)) wake_ctrl_d = PWDATA[7:0];
      if (hit(PADDR, OFS_PA_OE))     pa_oe_d     = PWDATA[3:0];
      if (hit(PADDR, OFS_PA_OUT))    pa_out_d    = PWDATA[3:0];
      if (hit(PADDR, OFS_IRQ_MASK)) begin
        irq_mask_d = PWDATA[NUM_EVENTS-1:0];
      end
    end
  end

  // Configuration state; reset gives 12 MHz, port mode, all inputs
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      cpu_ctrl_q  <= RST_CPU_CTRL;
      if_cfg_q    <= RST_IF_CFG;
      pa_cfg_q    <= RST_BYTE;
      irq_type_q  <= RST_BYTE;
      fifo_pol_q  <= RST_BYTE;
      wake_ctrl_q <= RST_BYTE;
      pa_oe_q     <= RST_NIBBLE;
      pa_out_q    <= RST_NIBBLE;
      irq_mask_q  <= '0;
    end else begin
      cpu_ctrl_q  <= cpu_ctrl_d;
      if_cfg_q    <= if_cfg_d;
      pa_cfg_q    <= pa_cfg_d;
      irq_type_q  <= irq_type_d;
      fifo_pol_q  <= fifo_pol_d;
      wake_ctrl_q <= wake_ctrl_d;
      pa_oe_q     <= pa_oe_d;
      pa_out_q    <= pa_out_d;
      irq_mask_q  <= irq_mask_d;
    end
  end

  // -------------------------------------------------------------
  // Clock output pin
  // -------------------------------------------------------------
  logic [1:0] speed;

  assign speed = cpu_ctrl_q[CPU_SPD_LO+1:CPU_SPD_LO];

  // Source select and tri-state
  always_comb begin
    case (speed)
      SPD_12:  CLOCK_OUTPUT_PIN_O = CLK12_SRC;
      SPD_24:  CLOCK_OUTPUT_PIN_O = CLK24_SRC;
      default: CLOCK_OUTPUT_PIN_O = CLK48_SRC;
    endcase
    CLOCK_OUTPUT_PIN_OE_N = cpu_ctrl_q[CPU_TRI_BIT];
  end

  // -------------------------------------------------------------
  // Pin functions
  // -------------------------------------------------------------
  logic       ext_interrupt_0_input_sel;
  logic       ext_interrupt_1_input_sel;
  logic       oe_sel;
  logic       wake_sel;
  logic [3:0] alt_fn;
  logic [3:0] pa_out_r_q;
  logic [3:0] pa_oe_n_q, pa_oe_n_d;

  assign ext_interrupt_0_input_sel = pa_cfg_q[PA_CFG_EXT_INTERRUPT_0_INPUT];
  assign ext_interrupt_1_input_sel = pa_cfg_q[PA_CFG_EXT_INTERRUPT_1_INPUT];
  assign oe_sel   = (if_cfg_q == IF_SLAVE);
  assign wake_sel = wake_ctrl_q[WAKE_SEL_BIT] & ~pa_oe_q[3];
  assign alt_fn   = {wake_sel, oe_sel, ext_interrupt_1_input_sel, ext_interrupt_0_input_sel};

  // Alternate functions are inputs only, so their drivers stay off
  always_comb begin
    pa_oe_n_d = ~(pa_oe_q & ~alt_fn);
  end

  // Registered pin drive
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      pa_out_r_q <= RST_NIBBLE;
      pa_oe_n_q  <= 4'hF;
    end else begin
      pa_out_r_q <= pa_out_q;
      pa_oe_n_q  <= pa_oe_n_d;
    end
  end

  assign PORT_A_OUT     = pa_out_r_q;
  assign PORT_A_OE_N    = pa_oe_n_q;
  assign INTERFACE_MODE = if_cfg_q;

  // FIFO drivers enabled when the pin matches its active level
  assign FIFO_DRIVE_EN = oe_sel &
    (PORT_A_IN[2] == fifo_pol_q[FIFO_POL_OE]);

  // -------------------------------------------------------------
  // External interrupt inputs
  // -------------------------------------------------------------
  logic [1:0] int_req;
  logic [1:0] int_edge;

  assign int_edge = {irq_type_q[IRQ_TYPE_IT1], irq_type_q[IRQ_TYPE_IT0]};

  // One conditioner per interrupt input
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_int
      irq_input_sense u_sense (
        .clk       (CLOCK),
        .rst_n     (rst_n),
        .pin_n     (PORT_A_IN[gi]),
        .edge_mode (int_edge[gi]),
        .active    (alt_fn[gi]),
        .request   (int_req[gi])
      );
    end
  endgenerate

  // -------------------------------------------------------------
  // Second wake input and suspend control
  // -------------------------------------------------------------
  logic   wake_en;
  logic   wake_asserted;
  logic   wake_prev_q, wake_prev_d;
  logic   wake_toggle;
  logic   susp_req;
  logic   refuse;
  logic   wake_evt;
  power_e pw_q, pw_d;

  assign wake_en       = wake_sel & wake_ctrl_q[WAKE_EN_BIT];
  assign wake_asserted = wake_en &
    (PORT_A_IN[3] == wake_ctrl_q[WAKE_POL_BIT]);
  assign wake_toggle   = wake_en & (PORT_A_IN[3] != wake_prev_q);
  assign susp_req      = wr & hit(PADDR, OFS_SUSPEND) &
                         PWDATA[SUSP_REQ_BIT];

  // Power state sequencing
  always_comb begin
    pw_d        = pw_q;
    wake_prev_d = PORT_A_IN[3];
    refuse      = 1'b0;
    wake_evt    = 1'b0;
    case (pw_q)
      PW_RUN: begin
        if (susp_req) begin
          if (wake_asserted) begin
            refuse = 1'b1;
          end else begin
            pw_d = PW_SUSPENDED;
          end
        end
      end
      PW_SUSPENDED: begin
        if (wake_toggle) begin
          pw_d     = PW_RUN;
          wake_evt = 1'b1;
        end
      end
      default: pw_d = PW_RUN;
    endcase
  end

  // Power state and previous wake pin level
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      pw_q        <= PW_RUN;
      wake_prev_q <= 1'b1; // Idle level of the pulled-up pin
    end else begin
      pw_q        <= pw_d;
      wake_prev_q <= wake_prev_d;
    end
  end

  assign SUSPENDED = (pw_q == PW_SUSPENDED);
  assign OSC_RUN   = (pw_q == PW_RUN);

  // -------------------------------------------------------------
  // Interrupt status
  // -------------------------------------------------------------
  logic [NUM_EVENTS-1:0] events;
  logic [NUM_EVENTS-1:0] irq_stat_q, irq_stat_d;

  assign events = {refuse, wake_evt, int_req};

  // Sticky bits, write one to clear; a new event wins over a clear
  always_comb begin
    irq_stat_d = irq_stat_q;
    if (wr && hit(PADDR, OFS_IRQ_STAT)) begin
      irq_stat_d = irq_stat_q & ~PWDATA[NUM_EVENTS-1:0];
    end
    irq_stat_d = irq_stat_d | events;
  end

  // Status register
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  assign IRQ = |(irq_stat_q & irq_mask_q);

  // -------------------------------------------------------------
  // APB read data and error
  // -------------------------------------------------------------
  logic [31:0] rdata_q, rdata_d;
  logic        err_q, err_d;

  // Read mux evaluated in the setup phase
  always_comb begin
    rdata_d = rdata_q;
    err_d   = err_q;
    if (setup) begin
      rdata_d = '0;
      err_d   = ~mapped(PADDR);
      case (PADDR)
        OFS_CPU_CTRL:  rdata_d[7:0] = cpu_ctrl_q;
        OFS_IF_CFG:    rdata_d[1:0] = if_cfg_q;
        OFS_PA_CFG:    rdata_d[7:0] = pa_cfg_q;
        OFS_IRQ_TYPE:  rdata_d[7:0] = irq_type_q;
        OFS_FIFO_POL:  rdata_d[7:0] = fifo_pol_q;
        OFS_WAKE_CTRL: rdata_d[7:0] = wake_ctrl_q;
        OFS_PA_OE:     rdata_d[3:0] = pa_oe_q;
        OFS_PA_OUT:    rdata_d[3:0] = pa_out_q;
        OFS_PA_PINS:   rdata_d[3:0] = PORT_A_IN;
        OFS_SUSPEND:   rdata_d[SUSP_REQ_BIT] = SUSPENDED;
        OFS_IRQ_STAT:  rdata_d[NUM_EVENTS-1:0] = irq_stat_q;
        OFS_IRQ_MASK:  rdata_d[NUM_EVENTS-1:0] = irq_mask_q;
        default:       rdata_d = '0;
      endcase
    end
  end

  // Read data and error flops
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
      err_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  assign PRDATA  = rdata_q;
  assign PSLVERR = PREADY & err_q;

endmodule

// [testbench/board_model.sv]
// Board-side model: locked clock sources and the four port A wires.
// Assumes the bench sets the board's drive levels and enables.
`timescale 1ns/10ps
module board_model (
  // Clock sources
  output logic       clk12,
  output logic       clk24,
  output logic       clk48,
  // Board drive of the port wires
  input  wire logic [3:0] drive_lvl,
  input  wire logic [3:0] drive_en,
  // Device drive of the port wires
  input  wire logic [3:0] pa_out,
  input  wire logic [3:0] pa_oe_n,
  // Resolved wire levels
  output logic [3:0] pin_lvl
);
  // ---------------------------------------------------------------
  // Sources divided from one edge, so they stay phase locked
  // ---------------------------------------------------------------
  initial begin
    clk12 = 1'b0;
    clk24 = 1'b0;
    clk48 = 1'b0;
    forever #10.42 clk48 = ~clk48;
  end
  always @(posedge clk48) clk24 <= ~clk24;
  always @(posedge clk24) clk12 <= ~clk12;

  // Wire level: device first, then board, else the pull-up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_lvl[i] = !pa_oe_n[i] ? pa_out[i] :
                   drive_en[i] ? drive_lvl[i] : 1'b1;
    end
  end
endmodule

// [testbench/pa_mux_sva.sv]
// Checker: port-level properties of the port A pin-function block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module pa_mux_sva
  import pa_mux_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        RESETN,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0]  PORT_A_IN,
  input wire logic [3:0]  PORT_A_OE_N,
  input wire logic        CLOCK_OUTPUT_PIN_OE_N,
  input wire logic        FIFO_DRIVE_EN,
  input wire logic [1:0]  INTERFACE_MODE,
  input wire logic        OSC_RUN,
  input wire logic        SUSPENDED
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  // Completed register writes
  logic wr_acc;
  logic susp_wr;
  assign wr_acc  = PSEL && PENABLE && PWRITE;
  assign susp_wr = wr_acc && PADDR == OFS_SUSPEND && PWDATA[SUSP_REQ_BIT];

  // Shadow of the wake controls, updated by the same writes
  logic [7:0] wake_sh;
  logic       oe3_sh;
  logic       wake_on;
  logic       wake_held;
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      wake_sh <= 8'h00;
      oe3_sh  <= 1'b0;
    end else begin
      if (wr_acc && PADDR == OFS_WAKE_CTRL) wake_sh <= PWDATA[7:0];
      if (wr_acc && PADDR == OFS_PA_OE) oe3_sh <= PWDATA[3];
    end
  end
  assign wake_on   = wake_sh[WAKE_SEL_BIT] && !oe3_sh &&
                     wake_sh[WAKE_EN_BIT];
  assign wake_held = wake_on && PORT_A_IN[3] == wake_sh[WAKE_POL_BIT];

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  clk_tristate_a: assert property (
    wr_acc && PADDR == OFS_CPU_CTRL |=>
    CLOCK_OUTPUT_PIN_OE_N == $past(PWDATA[CPU_TRI_BIT]))
    else $error("clock output enable does not follow write");
  mode_write_a: assert property (
    wr_acc && PADDR == OFS_IF_CFG |=>
    INTERFACE_MODE == $past(PWDATA[1:0]))
    else $error("interface mode does not follow write");
  reset_state_a: assert property (
    $rose(RESETN) |-> PORT_A_OE_N == 4'hF && !SUSPENDED &&
    INTERFACE_MODE == IF_PORT_A && !CLOCK_OUTPUT_PIN_OE_N)
    else $error("state after reset wrong");
  fifo_mode_a: assert property (
    FIFO_DRIVE_EN |-> INTERFACE_MODE == IF_SLAVE)
    else $error("fifo drive outside slave mode");
  fifo_in_only_a: assert property (
    INTERFACE_MODE == IF_SLAVE && $past(INTERFACE_MODE) == IF_SLAVE
    |-> PORT_A_OE_N[2])
    else $error("output enable pin driven");
  osc_run_a: assert property (
    $rose(OSC_RUN) |-> $past(wake_on))
    else $error("oscillator restarted with wake disabled");
  suspend_refuse_a: assert property (
    susp_wr && wake_held |=> !SUSPENDED)
    else $error("suspend entered while wake asserted");
  suspend_req_a: assert property (
    $rose(SUSPENDED) |-> $past(susp_wr))
    else $error("suspend without request");
  wake_pin_a: assert property (
    $fell(SUSPENDED) |->
    $past(PORT_A_IN[3]) != $past(PORT_A_IN[3], 2) ||
    $past(PORT_A_IN[3], 2) != $past(PORT_A_IN[3], 3))
    else $error("wake without pin transition");

  // Main scenarios reached
  cover property ($rose(SUSPENDED));
  cover property ($fell(SUSPENDED));
  cover property (FIFO_DRIVE_EN);
endmodule

bind port_a_pin_function_select pa_mux_sva chk (
  .CLOCK(CLOCK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PORT_A_IN(PORT_A_IN), .PORT_A_OE_N(PORT_A_OE_N),
  .CLOCK_OUTPUT_PIN_OE_N(CLOCK_OUTPUT_PIN_OE_N),
  .FIFO_DRIVE_EN(FIFO_DRIVE_EN), .INTERFACE_MODE(INTERFACE_MODE),
  .OSC_RUN(OSC_RUN), .SUSPENDED(SUSPENDED));

// [testbench/port_a_pin_function_select_test.sv]
// Testbench: register table loop, then clock, port, FIFO, interrupt,
// wake and reset cases. Assumes the board model drives the wires.
`timescale 1ns/10ps
module port_a_pin_function_select_test
  import pa_mux_pkg::*;
;
  logic        clock, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        c12, c24, c48, clk_o, clk_oe_n, fifo_en, osc, susp, irq, e;
  logic [3:0]  pa_in, pa_out, pa_oe_n, drv, drv_en;
  logic [1:0]  if_mode;
  int          fails, check_count;
  typedef struct {logic [7:0] a; logic [31:0] d, x; logic err;} row_s;
  row_s rows [10] = '{'{OFS_CPU_CTRL, 32'h1A, 32'h1A, 1'b0},
    '{OFS_IF_CFG, 32'h3, 32'h3, 1'b0}, '{OFS_PA_CFG, 32'h3, 32'h3, 1'b0},
    '{OFS_IRQ_TYPE, 32'h5, 32'h5, 1'b0},
    '{OFS_FIFO_POL, 32'h10, 32'h10, 1'b0},
    '{OFS_WAKE_CTRL, 32'h92, 32'h92, 1'b0},
    '{OFS_PA_OE, 32'hF, 32'hF, 1'b0}, '{OFS_PA_OUT, 32'hF, 32'hF, 1'b0},
    '{OFS_IRQ_MASK, 32'hF, 32'hF, 1'b0}, '{8'h30, 32'hFF, 32'h0, 1'b1}};

  board_model board (.clk12(c12), .clk24(c24), .clk48(c48),
    .drive_lvl(drv), .drive_en(drv_en), .pa_out(pa_out),
    .pa_oe_n(pa_oe_n), .pin_lvl(pa_in));
  port_a_pin_function_select uut (.CLOCK(clock), .RESETN(resetn),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CLK12_SRC(c12), .CLK24_SRC(c24), .CLK48_SRC(c48),
    .CLOCK_OUTPUT_PIN_O(clk_o), .CLOCK_OUTPUT_PIN_OE_N(clk_oe_n),
    .PORT_A_IN(pa_in), .PORT_A_OUT(pa_out), .PORT_A_OE_N(pa_oe_n),
    .FIFO_DRIVE_EN(fifo_en), .INTERFACE_MODE(if_mode), .OSC_RUN(osc),
    .SUSPENDED(susp), .IRQ(irq));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, x);
    check_count++;
    if (seen !== x) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, x, seen);
    end
  endtask
  // One APB transfer, waiting for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      n++;
      if (n > 16) begin
        fails++;
        report_and_stop();
      end
      @(posedge clock);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input int x);
    apb(1'b0, a, 32'h0);
    check(nm, r, x);
  endtask
  task automatic pins(input logic [3:0] v, input int n);
    @(posedge clock);
    drv <= v;
    repeat (n) @(posedge clock);
  endtask
  // Output clock compared with the chosen source between edges
  task automatic check_clk(input int s);
    repeat (8) begin
      @(posedge c48);
      #2;
      check("clk_out", clk_o, (s == 0) ? c12 : (s == 1) ? c24 : c48);
    end
  endtask

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {fails, check_count} = '0;
    drv = 4'hF;
    drv_en = 4'hF;
    resetn = 1'b0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    check("oe_n", pa_oe_n, 4'hF);
    check("if_mode", if_mode, IF_PORT_A);
    check_clk(0);
    foreach (rows[i]) rd("reset_val", rows[i].a, 0);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      rd("readback", rows[i].a, rows[i].x);
      check("slverr", e, rows[i].err);
      apb(1'b1, rows[i].a, 32'h0);
    end
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, OFS_CPU_CTRL, s << CPU_SPD_LO);
      check_clk(s);
    end
    apb(1'b1, OFS_CPU_CTRL, 32'h2);
    repeat (2) @(posedge clock);
    check("clk_oe_n", clk_oe_n, 1'b1);
    apb(1'b1, OFS_CPU_CTRL, 32'h0);
    apb(1'b1, OFS_PA_OE, 32'hF);
    apb(1'b1, OFS_PA_OUT, 32'h5);
    rd("pins_out", OFS_PA_PINS, 5);
    check("pa_oe_n", pa_oe_n, 4'h0);
    apb(1'b1, OFS_PA_OE, 32'h0);
    pins(4'hA, 2);
    rd("pins_in", OFS_PA_PINS, 10);
    apb(1'b1, OFS_IF_CFG, 32'h3);
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, OFS_FIFO_POL, p << FIFO_POL_OE);
      for (int l = 0; l < 2; l++) begin
        pins({1'b1, l[0], 2'b11}, 1);
        check("fifo_en", fifo_en, l == p);
      end
    end
    apb(1'b1, OFS_IF_CFG, 32'h0);
    pins(4'hB, 1);
    check("fifo_port", fifo_en, 1'b0);
    apb(1'b1, OFS_IRQ_MASK, 32'hF);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, OFS_PA_CFG, 32'h3);
      apb(1'b1, OFS_IRQ_TYPE, 32'h0);
      pins(4'hF ^ (1 << i), 3);
      rd("level", OFS_IRQ_STAT, 1 << i);
      check("irq", irq, 1'b1);
      apb(1'b1, OFS_IRQ_STAT, 32'hF);
      rd("level_again", OFS_IRQ_STAT, 1 << i);
      apb(1'b1, OFS_IRQ_TYPE, i ? 32'h4 : 32'h1);
      apb(1'b1, OFS_IRQ_STAT, 32'hF);
      rd("edge_hold", OFS_IRQ_STAT, 0);
      pins(4'hF, 1);
      pins(4'hF ^ (1 << i), 3);
      rd("edge", OFS_IRQ_STAT, 1 << i);
      apb(1'b1, OFS_IRQ_MASK, 32'h0);
      repeat (2) @(posedge clock);
      check("irq_masked", irq, 1'b0);
      apb(1'b1, OFS_IRQ_MASK, 32'hF);
      pins(4'hF, 1);
      apb(1'b1, OFS_PA_CFG, 32'h0);
      apb(1'b1, OFS_IRQ_STAT, 32'hF);
      pins(4'hF ^ (1 << i), 3);
      rd("port_bit", OFS_IRQ_STAT, 0);
      pins(4'hF, 1);
    end
    apb(1'b1, OFS_WAKE_CTRL, 32'h82);
    apb(1'b1, OFS_SUSPEND, 32'h1);
    repeat (2) @(posedge clock);
    check("suspended", susp, 1'b1);
    pins(4'h7, 3);
    check("woken", susp, 1'b0);
    rd("wake_stat", OFS_IRQ_STAT, 4);
    apb(1'b1, OFS_IRQ_STAT, 32'hF);
    apb(1'b1, OFS_SUSPEND, 32'h1);
    repeat (2) @(posedge clock);
    check("refused", susp, 1'b0);
    rd("refuse_stat", OFS_IRQ_STAT, 8);
    apb(1'b1, OFS_WAKE_CTRL, 32'h92);
    apb(1'b1, OFS_SUSPEND, 32'h1);
    repeat (2) @(posedge clock);
    check("susp_pol", susp, 1'b1);
    pins(4'hF, 3);
    check("wake_pol", susp, 1'b0);
    apb(1'b1, OFS_WAKE_CTRL, 32'h80);
    apb(1'b1, OFS_SUSPEND, 32'h1);
    pins(4'h7, 3);
    check("wake_off", susp, 1'b1);
    @(posedge clock);
    resetn <= 1'b0;
    @(posedge clock);
    check("rst_susp", susp, 1'b0);
    check("rst_osc", osc, 1'b1);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    rd("rst_wake", OFS_WAKE_CTRL, 0);
    report_and_stop();
  end
endmodule
